/* design/asc_pkg.sv */
// ------------------------------------------------------------
// Constants and types for the command and readback block
// ------------------------------------------------------------
// Contract
// - No-op is 00h 00h, check byte D7h
// - All-zero readback input in CRC mode sets error
// - Writing one to error flag clears it
// - Read command answered in the following frame
// - Read byte is 40h plus address
// - Unmapped read address returns 00h
// - Register byte MSB first, then 00h padding
// - Leading pad bytes excluded from input check
// - Output check byte covers all preceding bytes
// - Write is 80h plus address, then data
// - Unmapped writes are dropped silently
// - Input check mismatch locks writes except status
// - Error flag reported in status header
// - Conversion data shift out without command
// - Conversion result buffered, readable repeatedly
// - Pending read replaces conversion data once
// - Status header included in output check
// - Read past MSB byte clears ready bit
// - Pin holds level or follows ready before SCLK
// - Ready returns high at MSB byte eighth edge except in one-shot
// - Data field two or three bytes
// - Decode only last 16 or 24 bits
// - SPI mode 1, sample falling, shift rising
package asc_pkg;

  // ------------------------------------------------------------
  // Command encodings
  // ------------------------------------------------------------
  localparam logic [7:0] ASC_CMD_NOP = 8'h00;
  localparam logic [7:0] ASC_NOP_CHECK = 8'hD7;
  localparam logic [7:0] ASC_CMD_READ = 8'h40;
  localparam logic [7:0] ASC_CMD_WRITE = 8'h80;
  localparam logic [7:0] ASC_CRC_POLY = 8'h07;
  localparam logic [7:0] ASC_CRC_INIT = 8'hFF;
  localparam logic [7:0] ASC_PAD = 8'h00;
  localparam logic [7:0] ASC_UNMAPPED = 8'h00;

  // ------------------------------------------------------------
  // Register map layout
  // ------------------------------------------------------------
  localparam logic [3:0] ASC_STATUS_ADDR = 4'h0;
  localparam int ASC_ST_READY = 0;
  localparam int ASC_ST_ERR = 1;
  localparam int ASC_NUM_REGS = 10;
  localparam logic [7:0] ASC_REG_RST = 8'h00;

  // ------------------------------------------------------------
  // Frame geometry, in SCLK edges and bytes
  // ------------------------------------------------------------
  localparam logic [5:0] ASC_MSB_EDGE = 6'h08;
  localparam logic [5:0] ASC_MSB_EDGE_ST = 6'h10;
  localparam logic [5:0] ASC_MAX_BITS = 6'h28;
  localparam int ASC_FRAME_BYTES = 5;

  // ------------------------------------------------------------
  // Carriers and state
  // ------------------------------------------------------------
  typedef struct packed {
    logic crc_en;
    logic status_en;
    logic res24;
    logic pin_mode;
    logic oneshot;
  } asc_cfg_t;

  typedef struct packed {
    logic [39:0] word;
    logic conv;
    logic [5:0] msb_edge;
  } asc_tx_t;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic hit_s1;
    logic hit_s2;
    logic hit_s3;
    logic seen;
    logic crc_err;
    logic ready;
    logic data_ready_n_n;
    logic rd_pend;
    logic rd_stage;
    logic [3:0] rd_addr;
    logic [7:0] rd_byte;
    logic [23:0] conv_buf;
    asc_tx_t tx;
  } asc_sys_t;

  typedef struct packed {
    logic [5:0] cnt;
    logic hit;
  } asc_fall_t;

  // One byte through the check polynomial, MSB first
  function automatic logic [7:0] asc_crc8(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ ASC_CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

endpackage

/* design/asc_reg_mem.sv */
`timescale 1ns/1ns
module asc_reg_mem #(
  parameter int NUM_REGS = asc_pkg::ASC_NUM_REGS
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic we_in,
  input wire logic [3:0] waddr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [3:0] raddr_in,
  output logic [7:0] rdata_out
);

  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] mem;
    logic [7:0] q;
  } asc_mem_t;

  asc_mem_t m_reg;
  asc_mem_t m_next;

  // ------------------------------------------------------------
  // Storage with registered read port
  // ------------------------------------------------------------
  always_comb begin
    m_next = m_reg;
    if (we_in && ({1'b0, waddr_in} < 5'(NUM_REGS))) begin
      m_next.mem[waddr_in] = wdata_in;
    end
    // Out of range reads give a defined value
    m_next.q = ({1'b0, raddr_in} < 5'(NUM_REGS)) ?
               m_reg.mem[raddr_in] : asc_pkg::ASC_UNMAPPED;
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      m_reg.mem <= '{default: asc_pkg::ASC_REG_RST};
      m_reg.q <= asc_pkg::ASC_REG_RST;
    end else begin
      m_reg <= m_next;
    end
  end

  assign rdata_out = m_reg.q;

endmodule

/* design/asc_spi_core.sv */
`timescale 1ns/1ns
module asc_spi_core #(
  parameter int NUM_REGS = asc_pkg::ASC_NUM_REGS
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire asc_pkg::asc_cfg_t cfg_in,
  input wire logic [23:0] conv_data_in,
  input wire logic conv_ready_in,
  input wire logic conv_start_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  output logic data_out_ready_pin_out,
  output logic data_out_ready_pin_oe_out,
  output logic data_ready_n_out,
  output logic crc_error_flag_out
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  asc_pkg::asc_sys_t s_reg;
  asc_pkg::asc_sys_t s_next;
  asc_pkg::asc_fall_t f_reg;
  asc_pkg::asc_fall_t f_next;
  logic [5:0] idx_reg;
  logic [5:0] idx_next;
  logic sdo_reg;
  logic [23:0] rx_sh_reg;
  logic [5:0] bits_reg;
  logic [7:0] cmd_b1;
  logic [7:0] cmd_b2;
  logic [7:0] cmd_chk;
  logic [3:0] cmd_addr;
  logic crc_ok;
  logic is_rd;
  logic is_wr;
  logic addr_ok;
  logic end_ev;
  logic start_ev;
  logic hit_ev;
  logic late_hit;
  logic rd_ev;
  logic wr_ok;
  logic mem_we;
  logic [7:0] mem_q;
  logic [3:0] mem_ra;
  logic [7:0] stat_b;

  // ------------------------------------------------------------
  // Link side, rising SCLK: output shifter
  // ------------------------------------------------------------
  // Bit index restarts while chip select is high
  always_comb begin
    idx_next = (idx_reg == asc_pkg::ASC_MAX_BITS) ?
               idx_reg : idx_reg + 6'd1;
  end

  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      idx_reg <= '0;
    end else begin
      idx_reg <= idx_next;
    end
  end

  // Frame word is held still by the system side while selected
  always_ff @(posedge sclk_in) begin
    if (idx_reg < asc_pkg::ASC_MAX_BITS) begin
      sdo_reg <= s_reg.tx.word[asc_pkg::ASC_MAX_BITS - 6'd1
                               - idx_reg];
    end else begin
      sdo_reg <= asc_pkg::ASC_PAD[0];
    end
  end

  // ------------------------------------------------------------
  // Link side, falling SCLK: input sampling and edge count
  // ------------------------------------------------------------
  always_comb begin
    f_next = f_reg;
    f_next.cnt = (f_reg.cnt == asc_pkg::ASC_MAX_BITS) ?
                 f_reg.cnt : f_reg.cnt + 6'd1;
    // Eighth edge of the top data byte, conversion frames only
    if (f_next.cnt == s_reg.tx.msb_edge && s_reg.tx.conv) begin
      f_next.hit = 1'b1;
    end
  end

  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end

  // Kept past chip select rise so the system side can decode it
  always_ff @(negedge sclk_in) begin
    if (f_reg.cnt == 6'd0) begin
      rx_sh_reg <= {23'h000000, sdi_in};
    end else begin
      rx_sh_reg <= {rx_sh_reg[22:0], sdi_in};
    end
    bits_reg <= f_next.cnt;
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  // Before the first SCLK the pin holds or mirrors ready
  assign data_out_ready_pin_out =
    (idx_reg != 6'd0 || !cfg_in.pin_mode) ?
    sdo_reg : s_reg.data_ready_n_n;
  assign data_out_ready_pin_oe_out = !cs_n_in;
  assign data_ready_n_out = s_reg.data_ready_n_n;
  assign crc_error_flag_out = s_reg.crc_err;

  // ------------------------------------------------------------
  // Command decode of the last bits shifted in
  // ------------------------------------------------------------
  // Leading pad bytes have already fallen off the shifter
  assign cmd_b1 = cfg_in.crc_en ? rx_sh_reg[23:16]
                                : rx_sh_reg[15:8];
  assign cmd_b2 = cfg_in.crc_en ? rx_sh_reg[15:8]
                                : rx_sh_reg[7:0];
  assign cmd_chk = rx_sh_reg[7:0];
  assign cmd_addr = cmd_b1[3:0];
  // Second byte counts in the check even for reads
  assign crc_ok = !cfg_in.crc_en ||
    (asc_pkg::asc_crc8(asc_pkg::asc_crc8(asc_pkg::ASC_CRC_INIT,
                                         cmd_b1), cmd_b2)
     == cmd_chk);
  assign is_rd = cmd_b1[7:4] == asc_pkg::ASC_CMD_READ[7:4];
  assign is_wr = cmd_b1[7:4] == asc_pkg::ASC_CMD_WRITE[7:4];
  assign addr_ok = {1'b0, cmd_addr} < 5'(NUM_REGS);

  // ------------------------------------------------------------
  // Frame events seen from the system clock
  // ------------------------------------------------------------
  assign end_ev = s_reg.cs_s2 && !s_reg.cs_s3;
  assign start_ev = !s_reg.cs_s2 && s_reg.cs_s3;
  assign hit_ev = s_reg.hit_s2 && !s_reg.hit_s3;
  // A frame cut right after the edge may outrun the sync
  assign late_hit = end_ev && !s_reg.seen && s_reg.tx.conv &&
                    (bits_reg >= s_reg.tx.msb_edge);
  assign rd_ev = hit_ev || late_hit;
  assign wr_ok = end_ev && crc_ok && is_wr && addr_ok &&
    (!s_reg.crc_err ||
     cmd_addr == asc_pkg::ASC_STATUS_ADDR);
  assign mem_we = wr_ok && cmd_addr != asc_pkg::ASC_STATUS_ADDR;
  assign stat_b = {6'h00, s_reg.crc_err, s_reg.ready};

  // Read address leads by a cycle so the answer meets rd_stage
  assign mem_ra = end_ev ? cmd_addr : s_reg.rd_addr;

  asc_reg_mem #(
    .NUM_REGS(NUM_REGS)
  ) u_mem (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .we_in(mem_we),
    .waddr_in(cmd_addr),
    .wdata_in(cmd_b2),
    .raddr_in(mem_ra),
    .rdata_out(mem_q)
  );

  // ------------------------------------------------------------
  // System side state
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] bt [asc_pkg::ASC_FRAME_BYTES];
    logic [23:0] dat;
    logic [7:0] crc;
    int k;
    int nb;
    bt = '{default: asc_pkg::ASC_PAD};
    dat = '0;
    crc = asc_pkg::ASC_CRC_INIT;
    k = 0;
    nb = 0;
    s_next = s_reg;
    // Synchronisers for chip select and the edge flag
    s_next.cs_s1 = cs_n_in;
    s_next.cs_s2 = s_reg.cs_s1;
    s_next.cs_s3 = s_reg.cs_s2;
    s_next.hit_s1 = f_reg.hit;
    s_next.hit_s2 = s_reg.hit_s1;
    s_next.hit_s3 = s_reg.hit_s2;
    if (start_ev) begin
      s_next.seen = 1'b0;
    end
    if (hit_ev) begin
      s_next.seen = 1'b1;
    end
    // Frame end: a pending read is used up once
    if (end_ev) begin
      s_next.rd_pend = 1'b0;
      if (!crc_ok) begin
        s_next.crc_err = 1'b1;
      end else if (is_rd) begin
        s_next.rd_pend = 1'b1;
        s_next.rd_stage = 1'b1;
        s_next.rd_addr = cmd_addr;
      end else if (wr_ok && cmd_addr == asc_pkg::ASC_STATUS_ADDR &&
                   cmd_b2[asc_pkg::ASC_ST_ERR]) begin
        s_next.crc_err = 1'b0;
      end
    end
    // Memory answers one cycle after the address settles
    if (s_reg.rd_stage && !end_ev) begin
      s_next.rd_stage = 1'b0;
      if (s_reg.rd_addr == asc_pkg::ASC_STATUS_ADDR) begin
        s_next.rd_byte = stat_b;
      end else if ({1'b0, s_reg.rd_addr} < 5'(NUM_REGS)) begin
        s_next.rd_byte = mem_q;
      end else begin
        s_next.rd_byte = asc_pkg::ASC_UNMAPPED;
      end
    end
    // Ready line and status ready bit
    if (conv_start_in) begin
      s_next.data_ready_n_n = 1'b1;
    end
    if (rd_ev) begin
      s_next.ready = 1'b0;
      if (!cfg_in.oneshot) begin
        s_next.data_ready_n_n = 1'b1;
      end
    end
    // New result wins over a same-cycle read attempt
    if (conv_ready_in) begin
      s_next.conv_buf = conv_data_in;
      s_next.ready = 1'b1;
      s_next.data_ready_n_n = 1'b0;
    end
    // Frame word is rebuilt only while deselected
    if (s_reg.cs_s2 && s_reg.cs_s3) begin
      dat = s_reg.rd_pend ? {s_reg.rd_byte, asc_pkg::ASC_PAD,
                             asc_pkg::ASC_PAD}
                          : s_reg.conv_buf;
      nb = cfg_in.res24 ? 3 : 2;
      if (cfg_in.status_en) begin
        bt[k] = stat_b;
        k = k + 1;
      end
      for (int i = 0; i < 3; i++) begin
        if (i < nb) begin
          bt[k] = dat[23 - 8 * i -: 8];
          k = k + 1;
        end
      end
      for (int i = 0; i < asc_pkg::ASC_FRAME_BYTES; i++) begin
        if (i < k) begin
          crc = asc_pkg::asc_crc8(crc, bt[i]);
        end
      end
      if (cfg_in.crc_en) begin
        bt[k] = crc;
      end
      for (int i = 0; i < asc_pkg::ASC_FRAME_BYTES; i++) begin
        s_next.tx.word[39 - 8 * i -: 8] = bt[i];
      end
      s_next.tx.conv = !s_reg.rd_pend;
      s_next.tx.msb_edge = cfg_in.status_en ?
        asc_pkg::ASC_MSB_EDGE_ST : asc_pkg::ASC_MSB_EDGE;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      s_reg <= '0;
      s_reg.cs_s1 <= 1'b1;
      s_reg.cs_s2 <= 1'b1;
      s_reg.cs_s3 <= 1'b1;
      s_reg.data_ready_n_n <= 1'b1;
      s_reg.tx.conv <= 1'b1;
      s_reg.tx.msb_edge <= asc_pkg::ASC_MSB_EDGE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (srst_in);

  a_bad_check_flag: assert property (
    end_ev && !crc_ok |=> s_reg.crc_err ##1 s_reg.crc_err)
    else $error("check mismatch did not set error flag");

  a_zero_input_err: assert property (
    end_ev && cfg_in.crc_en && rx_sh_reg == 24'h000000
    |=> s_reg.crc_err)
    else $error("all-zero input did not set error flag");

  a_nop_accepted: assert property (
    end_ev && cfg_in.crc_en && cmd_b1 == asc_pkg::ASC_CMD_NOP &&
    cmd_b2 == asc_pkg::ASC_CMD_NOP &&
    cmd_chk == asc_pkg::ASC_NOP_CHECK && !s_reg.crc_err
    |=> !s_reg.crc_err)
    else $error("valid no-op raised error flag");

  a_err_clear_w1: assert property (
    end_ev && crc_ok && is_wr &&
    cmd_addr == asc_pkg::ASC_STATUS_ADDR &&
    cmd_b2[asc_pkg::ASC_ST_ERR] |=> !s_reg.crc_err)
    else $error("write one did not clear error flag");

  a_write_locked: assert property (
    s_reg.crc_err |-> !mem_we)
    else $error("register written while error flag set");

  a_write_range: assert property (
    end_ev && is_wr && !addr_ok |-> !mem_we)
    else $error("out of range write reached storage");

  a_read_pending: assert property (
    end_ev && crc_ok && is_rd |=> s_reg.rd_pend ##1 s_reg.rd_pend)
    else $error("read command not held for next frame");

  a_unmapped_zero: assert property (
    end_ev && crc_ok && is_rd && !addr_ok
    |=> ##1 s_reg.rd_byte == asc_pkg::ASC_UNMAPPED)
    else $error("unmapped read did not return zero");

  a_ready_release: assert property (
    rd_ev && !cfg_in.oneshot && !conv_ready_in
    |=> s_reg.data_ready_n_n && !s_reg.ready)
    else $error("ready not released after top byte read");

  a_oneshot_hold: assert property (
    rd_ev && cfg_in.oneshot && !conv_start_in && !s_reg.data_ready_n_n
    |=> !s_reg.data_ready_n_n)
    else $error("one-shot ready released by read");

  a_conv_loaded: assert property (
    conv_ready_in |=> s_reg.conv_buf == $past(conv_data_in) &&
    !s_reg.data_ready_n_n && s_reg.ready)
    else $error("conversion result not buffered");

endmodule

/* dv/asc_host_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Host controller acting as mode 1 SPI master
// ------------------------------------------------------------
module asc_host_model (
  input wire logic pin_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out
);
  // Link idle: clock parked low, chip select high
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  // One frame, MSB first, 30 ns link clock only inside the frame
  task automatic frame(input logic [39:0] tx, input int nbits,
                       output logic [39:0] rx, output logic pre);
    rx = 40'h0;
    #7;
    cs_n_out = 1'b0;
    #40;
    pre = pin_in;
    for (int i = nbits - 1; i >= 0; i--) begin
      sclk_out = 1'b1;
      sdi_out = tx[i];
      #15;
      sclk_out = 1'b0;
      rx = {rx[38:0], pin_in};
      #15;
    end
    cs_n_out = 1'b1;
    // Released line must not keep looking valid
    sdi_out = ~sdi_out;
    #60;
  endtask
endmodule

/* dv/adc_spi_command_and_readback_tb.sv */
`timescale 1ns/1ns
module adc_spi_command_and_readback_tb;
  logic clk_sys;
  logic srst;
  asc_pkg::asc_cfg_t cfg;
  logic [23:0] conv_data;
  logic conv_ready;
  logic conv_start;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic pin;
  logic pin_oe;
  logic data_ready_n_n;
  logic err_flag;
  wire sdo_line;
  int fail_count;
  int checks_done;
  logic [15:0] lfsr_state;
  logic [7:0] regs [0:15];
  logic [23:0] dat;
  logic [7:0] rd_val;
  logic rdy;
  logic data_ready_n_exp;
  logic err;
  logic pend;
  logic [15:0] v;
  logic [3:0] a;
  logic last_bit;
  logic have_last;

  // ------------------------------------------------------------
  // Clock, device and host
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Pin floats whenever the device lets go of it
  assign sdo_line = pin_oe ? pin : 1'bz;

  asc_spi_core #(.NUM_REGS(asc_pkg::ASC_NUM_REGS)) i_dut (
    .clk_sys_in(clk_sys), .srst_in(srst), .cfg_in(cfg),
    .conv_data_in(conv_data), .conv_ready_in(conv_ready),
    .conv_start_in(conv_start), .sclk_in(sclk), .cs_n_in(cs_n),
    .sdi_in(sdi), .data_out_ready_pin_out(pin),
    .data_out_ready_pin_oe_out(pin_oe), .data_ready_n_out(data_ready_n_n),
    .crc_error_flag_out(err_flag)
  );

  asc_host_model i_host (
    .pin_in(sdo_line), .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi)
  );

  // ------------------------------------------------------------
  // Expectation helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] rnd();
    lfsr_state = {lfsr_state[14:0], lfsr_state[15] ^ lfsr_state[13]
                  ^ lfsr_state[12] ^ lfsr_state[10]};
    return lfsr_state;
  endfunction

  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    repeat (8) r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    return r;
  endfunction

  // Whole output frame, right aligned, check byte over all before it
  function automatic logic [39:0] exp_frame(input logic [7:0] st,
                                            input logic [23:0] d);
    logic [39:0] w;
    logic [7:0] c;
    logic [7:0] b;
    w = 40'h0;
    c = 8'hFF;
    if (cfg.status_en) begin
      w = {32'h0, st};
      c = crc8(c, st);
    end
    for (int i = 0; i < (cfg.res24 ? 3 : 2); i++) begin
      b = d[23 - 8 * i -: 8];
      w = {w[31:0], b};
      c = crc8(c, b);
    end
    if (cfg.crc_en) w = {w[31:0], c};
    return w;
  endfunction

  task automatic chk(input string what, input logic [39:0] exp,
                     input logic [39:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Stimulus tasks
  // ------------------------------------------------------------
  task automatic conv_new(input logic [23:0] d);
    @(posedge clk_sys);
    conv_data <= d;
    conv_ready <= 1'b1;
    @(posedge clk_sys);
    conv_ready <= 1'b0;
    repeat (2) @(posedge clk_sys);
    dat = d;
    rdy = 1'b1;
    data_ready_n_exp = 1'b0;
  endtask

  // Full-length frame; random leading pads stay outside the check
  task automatic xfer(input logic [7:0] b1, input logic [7:0] b2,
                      input logic bad);
    logic [39:0] tx;
    logic [39:0] rx;
    logic [39:0] ex;
    logic [7:0] good;
    logic [7:0] ck;
    logic pre;
    int n;
    n = (cfg.status_en ? 8 : 0) + (cfg.res24 ? 24 : 16);
    n = n + (cfg.crc_en ? 8 : 0);
    good = crc8(crc8(8'hFF, b1), b2);
    ck = bad ? 8'h00 : good;
    tx = bad ? 40'h0 : {rnd(), rnd(), 8'h00};
    if (cfg.crc_en) tx[23:0] = {b1, b2, ck};
    else tx[15:0] = {b1, b2};
    ex = exp_frame({6'h00, err, rdy}, pend ? {rd_val, 16'h0000} : dat);
    i_host.frame(tx, n, rx, pre);
    repeat (8) @(posedge clk_sys);
    if (cfg.pin_mode) chk("pin_pre", 40'(data_ready_n_exp), 40'(pre));
    else if (have_last) chk("pin_hold", 40'(last_bit), 40'(pre));
    chk("frame", ex, rx);
    last_bit = rx[0];
    have_last = 1'b1;
    if (!pend) begin
      rdy = 1'b0;
      if (!cfg.oneshot) data_ready_n_exp = 1'b1;
    end
    pend = 1'b0;
    if (cfg.crc_en && ck !== good) err = 1'b1;
    else if (b1[7:4] == 4'h4) begin
      pend = 1'b1;
      rd_val = (int'(b1[3:0]) < asc_pkg::ASC_NUM_REGS) ? regs[b1[3:0]]
                                                        : 8'h00;
    end else if (b1[7:4] == 4'h8) begin
      if (b1[3:0] == 4'h0) begin
        if (b2[1]) err = 1'b0;
      end else if (!err && int'(b1[3:0]) < asc_pkg::ASC_NUM_REGS) begin
        regs[b1[3:0]] = b2;
      end
    end
    chk("err_flag", 40'(err), 40'(err_flag));
    chk("data_ready_n_n", {39'h0, data_ready_n_exp}, {39'h0, data_ready_n_n});
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    srst = 1'b1;
    cfg = asc_pkg::asc_cfg_t'(5'h08);
    conv_data = 24'h000000;
    conv_ready = 1'b0;
    conv_start = 1'b0;
    fail_count = 0;
    checks_done = 0;
    lfsr_state = 16'h31BE;
    for (int i = 0; i < 16; i++) regs[i] = 8'h00;
    dat = 24'h000000;
    rd_val = 8'h00;
    {rdy, err, pend} = 3'h0;
    data_ready_n_exp = 1'b1;
    last_bit = 1'b0;
    have_last = 1'b0;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("data_ready_n_rst", 40'h1, {39'h0, data_ready_n_n});
    // Every resolution, header, check and pin mode combination
    for (int k = 0; k < 16; k++) begin
      v = rnd();
      @(posedge clk_sys);
      cfg <= asc_pkg::asc_cfg_t'({k[0], k[1], k[2], k[3], v[0]});
      a = 4'(1 + int'(v[3:0]) % 9);
      conv_new({rnd(), v[15:8]});
      xfer(8'h00, 8'h00, 1'b0);
      xfer(8'h00, 8'h00, 1'b0);
      xfer({4'h8, a}, v[15:8], 1'b0);
      xfer({4'h4, a}, 8'(rnd()), 1'b0);
      xfer({4'h8, 4'hB}, 8'hFF, 1'b0);
      xfer({4'h4, 4'hB}, 8'h00, 1'b0);
      xfer({4'h4, a}, 8'h00, 1'b0);
      if (cfg.crc_en) begin
        xfer(8'h00, 8'h00, 1'b1);
        xfer({4'h8, a}, ~v[15:8], 1'b0);
        xfer({4'h4, a}, 8'h00, 1'b0);
        xfer(8'h80, 8'h02, 1'b0);
      end
      @(posedge clk_sys);
      conv_start <= 1'b1;
      @(posedge clk_sys);
      conv_start <= 1'b0;
      repeat (2) @(posedge clk_sys);
      data_ready_n_exp = 1'b1;
      chk("data_ready_n_start", 40'h1, {39'h0, data_ready_n_n});
    end
    end_of_test();
  end

  // Roughly four times the expected run; cuts a hung handshake short
  initial begin
    #600000;
    fail_count++;
    end_of_test();
  end
endmodule
